/* File: bench/ilwf_host_model.sv */
`timescale 1ns/1ps
`include "ilwf_defines.svh"
// ************************************************
// host side of the word link
// ************************************************
module ilwf_host_model (
  input wire logic pclk,
  output logic link_clk,
  output logic [66:0] rx_word,
  output logic rx_valid,
  input wire logic [66:0] tx_word,
  input wire logic tx_valid
);
  logic [23:0] acc;
  logic [66:0] txq[$];

  // link clock runs free, phase unrelated to pclk
  initial begin
    link_clk = 1'b0;
    rx_word = '0;
    rx_valid = 1'b0;
    acc = `ILWF_CRC_INIT;
    #37;
    forever #200 link_clk = ~link_clk;
  end

  function automatic logic [23:0] crc_step(input logic [23:0] c,
                                           input logic [63:0] d);
    logic fb;
    for (int i = 63; i >= 0; i--) begin
      fb = c[23] ^ d[i];
      c = {c[22:0], 1'b0} ^ (fb ? `ILWF_CRC_POLY : 24'h000000);
    end
    return c;
  endfunction

  // word changes mid link period, stable over the rising edge
  task automatic drive(input logic inv, input logic [1:0] frm,
                       input logic [63:0] p);
    @(negedge link_clk);
    @(posedge pclk);
    rx_word <= {inv, frm, inv ? ~p : p};
    rx_valid <= 1'b1;
  endtask

  task automatic send_dw(input logic [63:0] p, input logic inv);
    acc = crc_step(acc, p);
    drive(inv, `ILWF_FRM_DAT, p);
  endtask

  // bad flips one remainder bit for the crc error case
  task automatic send_cw(input logic [63:0] p, input logic bad);
    logic [23:0] c;
    c = ~crc_step(acc, {p[63:24], 24'h000000});
    acc = `ILWF_CRC_INIT;
    c = c ^ {23'h000000, bad};
    drive(1'b0, `ILWF_FRM_CTL, {p[63:24], c});
  endtask

  task automatic quiet();
    @(negedge link_clk);
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_word <= ~rx_word;
  endtask

  always @(posedge link_clk) begin
    if (tx_valid === 1'b1) begin
      txq.push_back(tx_word);
    end
  end
endmodule

/* File: bench/interlaken_word_formatter_bench.sv */
`timescale 1ns/1ps
`include "ilwf_defines.svh"
`define CHK(a, b) \
  begin \
    n_checks++; \
    if ((a) !== (b)) begin \
      num_errors++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
  end
module interlaken_word_formatter_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic link_clk, rx_valid, tx_valid, tx_ready, rx_xoff, dgood;
  logic [66:0] rx_word, tx_word;
  logic [2:0] dnb;
  logic [63:0] rxd[$];
  ilwf_pkg::ilwf_tx_beat_t tx_beat;
  ilwf_pkg::ilwf_rx_beat_t rx_beat;
  int num_errors = 0;
  int n_checks = 0;

  ilwf_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link_clk(link_clk), .rx_word(rx_word), .rx_valid(rx_valid),
    .tx_word(tx_word), .tx_valid(tx_valid), .tx_beat(tx_beat),
    .tx_ready(tx_ready), .rx_beat(rx_beat), .rx_xoff(rx_xoff));
  ilwf_host_model host (.pclk(pclk), .link_clk(link_clk),
    .rx_word(rx_word), .rx_valid(rx_valid), .tx_word(tx_word),
    .tx_valid(tx_valid));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (rx_beat.valid === 1'b1) begin
      rxd.push_back(rx_beat.data);
    end
    if (rx_beat.done === 1'b1) begin
      dgood = rx_beat.good;
      dnb = rx_beat.nbytes;
    end
  end

  // ************************************************
  // bus and stream helpers
  // ************************************************
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    `CHK(pready, 1'b1)
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x,
                        input logic xe);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h00000000, d, e);
    `CHK(d, x)
    `CHK(e, xe)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, v, d, e);
  endtask

  task automatic push_beat(input ilwf_pkg::ilwf_tx_beat_t b);
    int n;
    @(posedge pclk);
    tx_beat <= b;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (tx_ready !== 1'b1 && n < 64);
    `CHK(tx_ready, 1'b1)
    @(posedge pclk);
  endtask

  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_regs();
    rd_chk(`ILWF_OFS_CTRL, 32'h00000003, 1'b0);
    rd_chk(`ILWF_OFS_IRQ_MASK, 32'h00000000, 1'b0);
    rd_chk(`ILWF_OFS_GOOD_CNT, 32'h00000000, 1'b0);
    rd_chk(8'h20, 32'h00000000, 1'b1);
    $display("test regs done");
  endtask

  task automatic t_tx();
    logic [63:0] d0, d1, p;
    logic [66:0] w;
    logic [23:0] acc;
    int s;
    d0 = 64'h0123456789ABCDEF;
    d1 = 64'hFEDCBA9876543210;
    wr(`ILWF_OFS_CTRL, 32'h00000007);
    repeat (2) @(posedge link_clk);
    host.txq.delete();
    push_beat({1'b1, 1'b0, 3'h0, d0});
    push_beat({1'b1, 1'b1, 3'h3, d1});
    @(posedge pclk);
    tx_beat <= '0;
    repeat (3) @(posedge link_clk);
    acc = `ILWF_CRC_INIT;
    s = -1;
    foreach (host.txq[i]) begin
      w = host.txq[i];
      p = w[66] ? ~w[63:0] : w[63:0];
      if (w[65:64] === `ILWF_FRM_CTL) begin
        `CHK(p[63], 1'b1)
        `CHK(p[56], 1'b1)
        `CHK(p[55], 1'b1)
        `CHK(p[54:24], 31'h00000000)
        acc = host.crc_step(acc, {p[63:24], 24'h000000});
        `CHK(p[23:0], ~acc)
        acc = `ILWF_CRC_INIT;
        if (p[62] === 1'b1 && s < 0) s = i;
      end else begin
        `CHK(w[65:64], `ILWF_FRM_DAT)
        acc = host.crc_step(acc, p);
      end
    end
    `CHK(s >= 0 && host.txq.size() > s + 3, 1'b1)
    if (s >= 0 && host.txq.size() > s + 3) begin
      p = host.txq[s][66] ? ~host.txq[s][63:0] : host.txq[s][63:0];
      `CHK(p[61], 1'b1)
      w = host.txq[s + 1];
      `CHK(w[66] ? ~w[63:0] : w[63:0], d0)
      w = host.txq[s + 2];
      `CHK(w[66] ? ~w[63:0] : w[63:0], {d1[63:40], 40'h0})
      w = host.txq[s + 3];
      p = w[66] ? ~w[63:0] : w[63:0];
      `CHK(p[60:57], 4'hB)
    end
    wr(`ILWF_OFS_CTRL, 32'h00000003);
    $display("test tx done");
  endtask

  task automatic t_starve();
    logic [66:0] w;
    logic [63:0] p;
    int k;
    repeat (2) @(posedge link_clk);
    host.txq.delete();
    push_beat({1'b1, 1'b0, 3'h0, 64'h0F0F0F0F0F0F0F0F});
    @(posedge pclk);
    tx_beat <= '0;
    repeat (3) @(posedge link_clk);
    k = -1;
    foreach (host.txq[i]) begin
      if (host.txq[i][65:64] === `ILWF_FRM_DAT && k < 0) k = i;
    end
    `CHK(k >= 0 && host.txq.size() > k + 1, 1'b1)
    if (k >= 0 && host.txq.size() > k + 1) begin
      w = host.txq[k + 1];
      p = w[66] ? ~w[63:0] : w[63:0];
      `CHK(w[65:64], `ILWF_FRM_CTL)
      `CHK(p[62], 1'b0)
      `CHK(p[60:57], `ILWF_EOP_ERR)
    end
    wr(`ILWF_OFS_CTRL, 32'h00000000);
    repeat (3) @(posedge link_clk);
    @(negedge pclk);
    `CHK(tx_valid, 1'b0)
    wr(`ILWF_OFS_CTRL, 32'h00000003);
    $display("test starve done");
  endtask

  task automatic t_xoff();
    host.send_cw({3'b100, 4'h0, 2'b11, 15'h7FFF, 16'h0, 24'h0}, 1'b0);
    host.quiet();
    repeat (6) @(posedge pclk);
    `CHK(rx_xoff, 1'b1)
    rd_chk(`ILWF_OFS_STATUS, 32'h00000009, 1'b0);
    host.send_cw({3'b100, 4'h0, 2'b10, 15'h7FFF, 16'h0, 24'h0}, 1'b0);
    host.quiet();
    repeat (6) @(posedge pclk);
    `CHK(rx_xoff, 1'b0)
    rd_chk(`ILWF_OFS_STATUS, 32'h00000008, 1'b0);
    $display("test xoff done");
  endtask

  task automatic t_rx(input logic sop, input logic [3:0] eop,
                      input logic bad, input logic [3:0] m,
                      input logic g, input logic [3:0] st);
    logic [31:0] d;
    logic e;
    apb(1'b0, `ILWF_OFS_IRQ_STAT, 32'h00000000, d, e);
    wr(`ILWF_OFS_IRQ_MASK, {28'h0, m});
    rxd.delete();
    dgood = 1'bx;
    host.send_cw({2'b11, sop, 4'h0, 1'b1, 32'h0, 24'h0}, 1'b0);
    host.send_dw(64'hA5A50F0F12345678, 1'b1);
    host.send_dw(64'h0011223344556677, 1'b0);
    host.send_cw({3'b100, eop, 1'b1, 32'h0, 24'h0}, bad);
    host.quiet();
    repeat (6) @(posedge pclk);
    `CHK(rxd.size(), 2)
    `CHK(rxd[0], 64'hA5A50F0F12345678)
    `CHK(rxd[1], 64'h0011223344556677)
    `CHK(dgood, g)
    `CHK(dnb, eop[2:0])
    `CHK(irq, |(st & m))
    apb(1'b0, `ILWF_OFS_IRQ_STAT, 32'h00000000, d, e);
    `CHK(d, {28'h0, st})
    @(negedge pclk);
    `CHK(irq, 1'b0)
    $display("test rx burst done");
  endtask

  task automatic t_refuse();
    host.send_dw(64'h00000000000000FF, 1'b0);
    host.drive(1'b0, 2'h0, 64'h0000000000000000);
    host.send_cw(64'h0000000000000000, 1'b0);
    host.quiet();
    repeat (6) @(posedge pclk);
    rd_chk(`ILWF_OFS_IRQ_STAT, 32'h00000006, 1'b0);
    $display("test refuse done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    num_errors++;
    summarize();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    tx_beat = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_tx();
    t_starve();
    t_xoff();
    t_rx(1'b1, 4'hB, 1'b0, 4'hF, 1'b1, 4'h8);
    t_rx(1'b1, 4'hB, 1'b1, 4'hF, 1'b0, 4'h1);
    t_rx(1'b0, 4'hB, 1'b0, 4'hF, 1'b0, 4'h2);
    t_rx(1'b1, 4'h1, 1'b0, 4'hF, 1'b0, 4'h2);
    t_rx(1'b1, 4'h8, 1'b0, 4'h0, 1'b1, 4'h8);
    t_refuse();
    rd_chk(`ILWF_OFS_GOOD_CNT, 32'h00000002, 1'b0);
    summarize();
  end
endmodule

/* File: rtl/ilwf_crc24.sv */
`timescale 1ns/1ps
`include "ilwf_defines.svh"
module ilwf_crc24 #(
  parameter logic [23:0] POLY = `ILWF_CRC_POLY
) (
  input wire logic [23:0] crc_in,
  input wire logic [63:0] data,
  output logic [23:0] crc_out
);
  // msb first, one bit per step
  always_comb begin
    crc_out = crc_in;
    for (int i = 63; i >= 0; i--) begin
      if (crc_out[23] ^ data[i]) begin
        crc_out = {crc_out[22:0], 1'b0} ^ POLY;
      end else begin
        crc_out = {crc_out[22:0], 1'b0};
      end
    end
  end
endmodule

/* File: rtl/ilwf_defines.svh */
`ifndef ILWF_DEFINES_SVH
`define ILWF_DEFINES_SVH

// ****************************************************
// register map
// ****************************************************
`define ILWF_OFS_CTRL 8'h00
`define ILWF_OFS_STATUS 8'h04
`define ILWF_OFS_IRQ_STAT 8'h08
`define ILWF_OFS_IRQ_MASK 8'h0C
`define ILWF_OFS_GOOD_CNT 8'h10
`define ILWF_CTRL_RST 3'h3
`define ILWF_CTRL_TX_EN 0
`define ILWF_CTRL_INV_EN 1
`define ILWF_CTRL_XOFF 2
`define ILWF_EV_CRC 0
`define ILWF_EV_PKT 1
`define ILWF_EV_FRM 2
`define ILWF_EV_GOOD 3

// ****************************************************
// word layout
// ****************************************************
`define ILWF_B_INV 66
`define ILWF_B_CTL 63
`define ILWF_B_TYPE 62
`define ILWF_B_SOP 61
`define ILWF_B_EOP 60
`define ILWF_B_RCAL 56
`define ILWF_B_XOFF 55
`define ILWF_FRM_CTL 2'h2
`define ILWF_FRM_DAT 2'h1
`define ILWF_EOP_NONE 4'h0
`define ILWF_EOP_ERR 4'h1
`define ILWF_CRC_POLY 24'h328B63
`define ILWF_CRC_INIT 24'hFFFFFF
`endif

/* File: rtl/ilwf_pkg.sv */
package ilwf_pkg;
  typedef enum logic [1:0] {
    ILWF_TX_IDLE = 2'b00,
    ILWF_TX_DATA = 2'b01
  } ilwf_tx_st_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [2:0] nbytes;
    logic [63:0] data;
  } ilwf_tx_beat_t;

  typedef struct packed {
    logic valid;
    logic done;
    logic good;
    logic [2:0] nbytes;
    logic [63:0] data;
  } ilwf_rx_beat_t;

  typedef struct packed {
    logic clk_prev;
    logic [23:0] rx_acc;
    logic rx_in_burst;
    logic rx_sop;
    logic rx_xoff;
    logic rx_rcal;
    ilwf_rx_beat_t rx_out;
    ilwf_tx_st_t tx_st;
    logic [23:0] tx_acc;
    logic [3:0] tx_pend_eop;
    logic [66:0] tx_word;
    logic tx_valid;
    logic signed [8:0] disp;
    logic [2:0] ctrl;
    logic [3:0] stat;
    logic [3:0] mask;
    logic [3:0] rd_cap;
    logic [15:0] good_cnt;
    logic [31:0] prdata;
    logic slverr;
  } ilwf_state_t;
endpackage

/* File: rtl/ilwf_sync.sv */
`timescale 1ns/1ps
module ilwf_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] out;
  } ilwf_sync_st_t;

  ilwf_sync_st_t st_q, st_d;

  always_comb begin
    st_d.meta = d;
    st_d.out = st_q.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.out;
endmodule

/* File: rtl/ilwf_top.sv */
`timescale 1ns/1ps
`include "ilwf_defines.svh"
module ilwf_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic link_clk,
  input wire logic [66:0] rx_word,
  input wire logic rx_valid,
  output logic [66:0] tx_word,
  output logic tx_valid,
  input wire ilwf_pkg::ilwf_tx_beat_t tx_beat,
  output logic tx_ready,
  output ilwf_pkg::ilwf_rx_beat_t rx_beat,
  output logic rx_xoff
);
  ilwf_pkg::ilwf_state_t q, d;
  logic lclk_s;
  logic rxv_s;
  logic [66:0] rxw_s;
  logic tick;
  logic rx_take;
  logic rx_cw;
  logic crc_ok;
  logic close;
  logic [63:0] rx_pay;
  logic [63:0] rx_crc_data;
  logic [23:0] rx_crc;
  logic tx_send;
  logic tx_is_cw;
  logic cw_type;
  logic [3:0] cw_eop;
  logic [63:0] cw_raw;
  logic [63:0] tx_crc_data;
  logic [63:0] tx_pay;
  logic [63:0] tx_plain;
  logic [23:0] tx_crc;
  logic [6:0] ones;
  logic signed [8:0] bal;
  logic inv;
  logic setup;
  logic access;
  logic addr_ok;
  logic [31:0] rd_val;
  logic [3:0] ev;

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [6:0] count_ones(input logic [63:0] w);
    logic [6:0] n;
    n = 7'h00;
    for (int i = 0; i < 64; i++) begin
      n = n + 7'(w[i]);
    end
    return n;
  endfunction

  // keeps the upper n byte lanes, all eight for n of zero
  function automatic logic [63:0] lane_mask(input logic [2:0] n);
    logic [63:0] m;
    m = 64'hFFFF_FFFF_FFFF_FFFF;
    if (n != 3'h0) begin
      m = ~(m >> {n, 3'b000});
    end
    return m;
  endfunction

  // ****************************************************
  // link sampling
  // ****************************************************
  ilwf_sync #(
    .WIDTH(69)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({link_clk, rx_valid, rx_word}),
    .q({lclk_s, rxv_s, rxw_s})
  );

  assign tick = lclk_s & ~q.clk_prev;

  // ****************************************************
  // receive decode
  // ****************************************************
  assign rx_take = tick & rxv_s;
  assign rx_pay = rxw_s[`ILWF_B_INV] ? ~rxw_s[63:0] : rxw_s[63:0];
  assign rx_cw = (rxw_s[65:64] == `ILWF_FRM_CTL) & rx_pay[`ILWF_B_CTL];
  assign rx_crc_data = rx_cw ? {rx_pay[63:24], 24'h000000} : rx_pay;
  assign crc_ok = (~rx_crc == rx_pay[23:0]);
  assign close = rx_take & rx_cw & q.rx_in_burst;

  ilwf_crc24 u_rx_crc (
    .crc_in(q.rx_acc),
    .data(rx_crc_data),
    .crc_out(rx_crc)
  );

  // ****************************************************
  // transmit encode
  // ****************************************************
  assign tx_send = tick & ((q.tx_st == ilwf_pkg::ILWF_TX_DATA) |
                           q.ctrl[`ILWF_CTRL_TX_EN]);
  assign tx_is_cw = (q.tx_st == ilwf_pkg::ILWF_TX_IDLE) | ~tx_beat.valid;
  assign tx_ready = tick & (q.tx_st == ilwf_pkg::ILWF_TX_DATA);
  assign cw_type = (q.tx_st == ilwf_pkg::ILWF_TX_IDLE) & tx_beat.valid;
  // a burst that runs dry is closed as an errored end
  assign cw_eop = (q.tx_st == ilwf_pkg::ILWF_TX_DATA) ?
                  `ILWF_EOP_ERR : q.tx_pend_eop;
  assign cw_raw = {1'b1, cw_type, cw_type, cw_eop, 1'b1,
                   q.ctrl[`ILWF_CTRL_XOFF], 31'h00000000,
                   24'h000000};
  assign tx_crc_data = tx_is_cw ? cw_raw :
                       tx_beat.last ?
                       (tx_beat.data & lane_mask(tx_beat.nbytes)) :
                       tx_beat.data;
  assign tx_pay = tx_is_cw ? {cw_raw[63:24], ~tx_crc} : tx_crc_data;

  ilwf_crc24 u_tx_crc (
    .crc_in(q.tx_acc),
    .data(tx_crc_data),
    .crc_out(tx_crc)
  );

  // invert when the word would push disparity further the same way
  assign ones = count_ones(tx_pay);
  assign bal = $signed({1'b0, ones, 1'b0}) - 9'sh040;
  assign inv = q.ctrl[`ILWF_CTRL_INV_EN] & (q.disp != 9'sh000) &
               (bal != 9'sh000) & (q.disp[8] == bal[8]);
  assign tx_plain = tx_word[`ILWF_B_INV] ? ~tx_word[63:0] : tx_word[63:0];

  // ****************************************************
  // apb decode
  // ****************************************************
  assign setup = psel & ~penable;
  assign access = psel & penable;

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    d = q;
    ev = 4'h0;
    addr_ok = 1'b1;
    rd_val = 32'h00000000;
    d.clk_prev = lclk_s;
    d.rx_out.valid = 1'b0;
    d.rx_out.done = 1'b0;
    if (rx_take) begin
      if (rxw_s[65:64] == `ILWF_FRM_DAT) begin
        if (q.rx_in_burst) begin
          d.rx_acc = rx_crc;
          d.rx_out.valid = 1'b1;
          d.rx_out.data = rx_pay;
        end else begin
          ev[`ILWF_EV_PKT] = 1'b1;
        end
      end else if (rxw_s[65:64] != `ILWF_FRM_CTL) begin
        ev[`ILWF_EV_FRM] = 1'b1;
      end else if (rx_pay[`ILWF_B_CTL]) begin
        ev[`ILWF_EV_CRC] = ~crc_ok;
        d.rx_xoff = rx_pay[`ILWF_B_XOFF];
        d.rx_rcal = rx_pay[`ILWF_B_RCAL];
        d.rx_acc = `ILWF_CRC_INIT;
        d.rx_in_burst = rx_pay[`ILWF_B_TYPE];
        d.rx_sop = rx_pay[`ILWF_B_TYPE] & rx_pay[`ILWF_B_SOP];
        if (q.rx_in_burst) begin
          // end code closes the previous burst
          d.rx_out.done = 1'b1;
          d.rx_out.good = crc_ok & q.rx_sop & rx_pay[`ILWF_B_EOP];
          d.rx_out.nbytes = rx_pay[59:57];
          ev[`ILWF_EV_PKT] = ~(q.rx_sop & rx_pay[`ILWF_B_EOP]);
          ev[`ILWF_EV_GOOD] = crc_ok & q.rx_sop & rx_pay[`ILWF_B_EOP];
        end
      end
    end
    if (tx_send) begin
      d.tx_word = {inv, tx_is_cw ? `ILWF_FRM_CTL : `ILWF_FRM_DAT,
                   inv ? ~tx_pay : tx_pay};
      d.disp = inv ? q.disp - bal : q.disp + bal;
      if (tx_is_cw) begin
        d.tx_acc = `ILWF_CRC_INIT;
        d.tx_pend_eop = `ILWF_EOP_NONE;
        d.tx_st = cw_type ? ilwf_pkg::ILWF_TX_DATA : ilwf_pkg::ILWF_TX_IDLE;
      end else begin
        d.tx_acc = tx_crc;
        if (tx_beat.last) begin
          d.tx_pend_eop = {1'b1, tx_beat.nbytes};
          d.tx_st = ilwf_pkg::ILWF_TX_IDLE;
        end
      end
    end
    if (tick) begin
      d.tx_valid = tx_send;
    end
    case (paddr)
      `ILWF_OFS_CTRL: rd_val = {29'h00000000, q.ctrl};
      `ILWF_OFS_STATUS: rd_val = {28'h0000000, q.rx_rcal, q.rx_in_burst,
                                  q.tx_st == ilwf_pkg::ILWF_TX_DATA,
                                  q.rx_xoff};
      `ILWF_OFS_IRQ_STAT: rd_val = {28'h0000000, q.stat};
      `ILWF_OFS_IRQ_MASK: rd_val = {28'h0000000, q.mask};
      `ILWF_OFS_GOOD_CNT: rd_val = {16'h0000, q.good_cnt};
      default: addr_ok = 1'b0;
    endcase
    if (setup) begin
      d.prdata = pwrite ? 32'h00000000 : rd_val;
      d.slverr = ~addr_ok;
      d.rd_cap = (!pwrite && paddr == `ILWF_OFS_IRQ_STAT) ? q.stat : 4'h0;
    end
    if (access & pwrite & addr_ok) begin
      if (paddr == `ILWF_OFS_CTRL) begin
        d.ctrl = pwdata[2:0];
      end
      if (paddr == `ILWF_OFS_IRQ_MASK) begin
        d.mask = pwdata[3:0];
      end
    end
    // only bits seen by the read are cleared; new events win
    if (access & ~pwrite) begin
      d.stat = (q.stat & ~q.rd_cap) | ev;
    end else begin
      d.stat = q.stat | ev;
    end
    if (ev[`ILWF_EV_GOOD]) begin
      d.good_cnt = q.good_cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.ctrl <= `ILWF_CTRL_RST;
      q.rx_acc <= `ILWF_CRC_INIT;
      q.tx_acc <= `ILWF_CRC_INIT;
    end else begin
      q <= d;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign prdata = q.prdata;
  assign pready = access;
  assign pslverr = access & q.slverr;
  assign irq = |(q.stat & q.mask);
  assign tx_word = q.tx_word;
  assign tx_valid = q.tx_valid;
  assign rx_beat = q.rx_out;
  assign rx_xoff = q.rx_xoff;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cw_sent;
    tx_send && tx_is_cw;
  endsequence

  sequence s_bad_close;
    close && !(q.rx_sop && rx_pay[`ILWF_B_EOP]);
  endsequence

  inv_restore_a: assert property (
    tx_send |=> tx_plain == $past(tx_pay)
  ) else $error("inversion flag does not restore payload");
  cw_frame_a: assert property (
    s_cw_sent |=> tx_word[65:64] == `ILWF_FRM_CTL
  ) else $error("control word framing wrong");
  dw_frame_a: assert property (
    tx_send && !tx_is_cw |=> tx_word[65:64] == `ILWF_FRM_DAT
  ) else $error("data word framing wrong");
  cw_control_a: assert property (
    s_cw_sent |=> tx_plain[`ILWF_B_CTL]
  ) else $error("control bit clear on sent word");
  type_burst_a: assert property (
    s_cw_sent |=> (q.tx_st == ilwf_pkg::ILWF_TX_DATA) ==
                  tx_plain[`ILWF_B_TYPE]
  ) else $error("type bit disagrees with burst start");
  sop_start_a: assert property (
    s_cw_sent |=> tx_plain[`ILWF_B_SOP] == tx_plain[`ILWF_B_TYPE]
  ) else $error("start flag wrong for single burst packet");
  eop_prev_a: assert property (
    s_cw_sent and (q.tx_st == ilwf_pkg::ILWF_TX_IDLE)
    |=> tx_plain[60:57] == $past(q.tx_pend_eop)
  ) else $error("end field not from preceding burst");
  eop_count_a: assert property (
    tx_ready && tx_beat.valid && tx_beat.last
    |=> q.tx_pend_eop == {1'b1, $past(tx_beat.nbytes)}
  ) else $error("byte count not latched for end field");
  lane_fill_a: assert property (
    tx_ready && tx_beat.valid && tx_beat.last && tx_beat.nbytes != 3'h0
    |=> (tx_plain & ~lane_mask($past(tx_beat.nbytes))) == 64'h0
  ) else $error("unused low byte lanes not zero");
  underrun_a: assert property (
    tick && q.tx_st == ilwf_pkg::ILWF_TX_DATA && !tx_beat.valid
    |=> tx_plain[60:57] == `ILWF_EOP_ERR
  ) else $error("starved burst not closed as errored");
  rcal_set_a: assert property (
    s_cw_sent |=> tx_plain[`ILWF_B_RCAL] && tx_plain[54:24] == 31'h0
  ) else $error("calendar reset clear or reserved bits set");
  crc_field_a: assert property (
    s_cw_sent |=> tx_plain[23:0] == ~$past(tx_crc) ##1
                  q.tx_acc == `ILWF_CRC_INIT
  ) else $error("control word crc or restart wrong");
  xoff_rx_a: assert property (
    rx_take && rx_cw |=> rx_xoff == $past(rx_pay[`ILWF_B_XOFF])
  ) else $error("flow-control off not taken from bit 55");
  bad_burst_a: assert property (
    s_bad_close |=> rx_beat.done && !rx_beat.good && q.stat[`ILWF_EV_PKT]
  ) else $error("burst lacking start or end not discarded");
  crc_err_a: assert property (
    close && !crc_ok |=> !rx_beat.good && q.stat[`ILWF_EV_CRC]
  ) else $error("crc mismatch not discarded or flagged");
  xoff_tx_a: assert property (
    s_cw_sent |=> tx_plain[`ILWF_B_XOFF] == $past(q.ctrl[`ILWF_CTRL_XOFF])
  ) else $error("flow-control off not sent in bit 55");
  // receive side; data restore, framing and byte count judged from the raw synchronised word
  rx_undo_a: assert property (
    rx_take && rxw_s[65:64] == `ILWF_FRM_DAT && q.rx_in_burst
    |=> rx_beat.valid &&
        (rx_beat.data ^ $past(rxw_s[63:0])) == {64{$past(rxw_s[66])}}
  ) else $error("received data word not restored");
  frm_err_a: assert property (
    rx_take && rxw_s[65] == rxw_s[64] |=> q.stat[`ILWF_EV_FRM]
  ) else $error("bad framing not flagged");
  rx_count_a: assert property (
    close |=> rx_beat.nbytes == $past(rxw_s[59:57] ^ {3{rxw_s[66]}})
  ) else $error("received byte count not passed on");
  good_count_a: assert property (
    close && crc_ok && q.rx_sop && rx_pay[`ILWF_B_EOP]
    |=> rx_beat.good && q.good_cnt == $past(q.good_cnt) + 16'h0001
  ) else $error("good burst not counted");
endmodule
